/* core/tpw_ctrl.sv */
/*
  tpw_ctrl: put and write sequencer between an APB host and up to
  sixteen terminals on a shared two-way data bus.
  assumes: terminal ack and data pins are asynchronous; the bench
  resolves the data bus from term_data_oe.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tpw_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  term_opcode_bus,
  output logic      [15:0] term_enable,
  output logic      [23:0] term_data_o,
  output logic             term_data_oe,
  input  wire logic [23:0] term_data_i,
  input  wire logic [15:0] terminal_ack_line,
  output logic             processor_asw,
  output logic      [15:0] scanner_answer_bus,
  output logic             seq_busy
);

  tpw_pkg::tpw_state_t state_reg, state_next;
  logic [23:0] instr_reg, data_reg, reply_reg;
  logic [15:0] sel_reg, false_reg, answer_reg;
  logic [15:0] ack_s1, ack_s2, sel_new, ack_false, ack_hit;
  logic [23:0] dat_s1, dat_s2, word_new;
  logic [7:0]  opc_new;
  logic [9:0]  cnt_reg;
  logic [3:0]  err_reg;
  logic        op_put_reg, op_write_reg, valid_ack_reg;
  logic        seq_false_reg, par_err_reg, ovf_reg;
  logic        wr_acc, rd_setup, hit, instr_wr, data_wr;
  logic        pfx_ok, chk_ok, tmo;
  logic [15:0] ans_put;
  logic [1:0]  pfx;

  // ----------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit      = (paddr <= tpw_pkg::ADDR_ERRSRC) && (paddr[1:0] == 2'h0);
  assign pslverr  = psel && penable && !hit;
  assign instr_wr = wr_acc && (paddr == tpw_pkg::ADDR_INSTR);
  assign data_wr  = wr_acc && (paddr == tpw_pkg::ADDR_DATA);
  assign pfx      = pwdata[tpw_pkg::OPC_LSB + 4 +: 2];
  assign pfx_ok   = !pwdata[tpw_pkg::OPC_LSB + 6]
                    && (pfx == tpw_pkg::PFX_PUT || pfx == tpw_pkg::PFX_WRITE);

  // read data sampled in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
    begin
      unique case (paddr)
        tpw_pkg::ADDR_INSTR:  prdata <= {8'h00, instr_reg};
        tpw_pkg::ADDR_DATA:   prdata <= {8'h00, data_reg};
        tpw_pkg::ADDR_STATUS: prdata <= {16'h0000, state_reg, 1'b0,
                                         ovf_reg, par_err_reg, seq_false_reg,
                                         valid_ack_reg, op_write_reg, op_put_reg,
                                         seq_busy};
        tpw_pkg::ADDR_REPLY:  prdata <= {8'h00, reply_reg};
        tpw_pkg::ADDR_ANSWER: prdata <= {16'h0000, answer_reg};
        tpw_pkg::ADDR_FALSE:  prdata <= {16'h0000, false_reg};
        tpw_pkg::ADDR_ERRSRC: prdata <= {28'h0000000, err_reg};
        default:              prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_s1 <= 16'h0000;
      ack_s2 <= 16'h0000;
      dat_s1 <= tpw_pkg::WORD_RESET;
      dat_s2 <= tpw_pkg::WORD_RESET;
    end
    else
    begin
      ack_s1 <= terminal_ack_line;
      ack_s2 <= ack_s1;
      dat_s1 <= term_data_i;
      dat_s2 <= dat_s1;
    end
  end

  // addressed terminal stays masked until the next drive step, so its
  // ack tail still in the synchroniser is not logged as a false ack
  assign ack_hit   = ack_s2 & sel_reg;
  assign ack_false = ack_s2 & ~sel_reg;
  assign tmo       = (cnt_reg >= tpw_pkg::ACK_TMO_CYC);

  tpw_word_builder u_word (
    .instr      (instr_reg),
    .data       (data_reg),
    .is_write   (op_write_reg),
    .sel_onehot (sel_new),
    .opcode_par (opc_new),
    .word       (word_new)
  );

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  assign chk_ok = valid_ack_reg && !seq_false_reg
                  && !(op_write_reg && !(^reply_reg));

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      tpw_pkg::ST_IDLE:
        if (instr_wr && pfx_ok)
          state_next = tpw_pkg::ST_ALERT;
      tpw_pkg::ST_ALERT:
        if (cnt_reg == tpw_pkg::ASW_CYC - 10'h001)
          state_next = tpw_pkg::ST_WAIT;
      tpw_pkg::ST_WAIT:
        if (data_wr)
          state_next = (op_put_reg && !pwdata[tpw_pkg::PERMIT_BIT])
                       ? tpw_pkg::ST_CLEAR : tpw_pkg::ST_DRIVE;
      tpw_pkg::ST_DRIVE:
        if (cnt_reg == tpw_pkg::SETTLE_CYC)
          state_next = tpw_pkg::ST_ENABLE;
      tpw_pkg::ST_ENABLE:
        if (|ack_hit)
          state_next = tpw_pkg::ST_CHECK;
        else if (tmo)
          state_next = tpw_pkg::ST_CLEAR;
      tpw_pkg::ST_CHECK:
        state_next = chk_ok ? tpw_pkg::ST_FINISH : tpw_pkg::ST_CLEAR;
      tpw_pkg::ST_FINISH:
        if (cnt_reg == tpw_pkg::ASW_CYC - 10'h001)
          state_next = tpw_pkg::ST_CLEAR;
      tpw_pkg::ST_CLEAR:
        state_next = tpw_pkg::ST_IDLE;
      default:
        state_next = tpw_pkg::ST_CLEAR;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= tpw_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 10'h000;
    else if (state_next != state_reg)
      cnt_reg <= 10'h000;
    else
      cnt_reg <= cnt_reg + 10'h001;
  end

  // ----------------------------------------------------------
  // instruction, data and opcode registers
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_reg    <= tpw_pkg::WORD_RESET;
      op_put_reg   <= 1'b0;
      op_write_reg <= 1'b0;
    end
    else if (state_reg == tpw_pkg::ST_IDLE && instr_wr)
    begin
      instr_reg    <= pwdata[23:0];
      op_put_reg   <= pfx_ok && pfx == tpw_pkg::PFX_PUT;
      op_write_reg <= pfx_ok && pfx == tpw_pkg::PFX_WRITE;
    end
    else if (state_reg == tpw_pkg::ST_CLEAR)
    begin
      op_put_reg   <= 1'b0;
      op_write_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_reg <= tpw_pkg::WORD_RESET;
    else if (state_reg == tpw_pkg::ST_CLEAR)
      data_reg <= tpw_pkg::WORD_RESET;
    else if (state_reg == tpw_pkg::ST_WAIT && data_wr)
      data_reg <= pwdata[23:0];
  end

  // ----------------------------------------------------------
  // terminal side drive
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg         <= 16'h0000;
      term_opcode_bus <= 8'h00;
      term_data_o     <= tpw_pkg::WORD_RESET;
      term_data_oe    <= 1'b0;
    end
    else if (state_reg == tpw_pkg::ST_CLEAR)
    begin
      term_opcode_bus <= 8'h00;
      term_data_o     <= tpw_pkg::WORD_RESET;
      term_data_oe    <= 1'b0;
    end
    else if (state_reg == tpw_pkg::ST_DRIVE)
    begin
      sel_reg         <= sel_new;
      term_opcode_bus <= opc_new;
      term_data_o     <= word_new;
      term_data_oe    <= 1'b1;
    end
    else if (state_reg == tpw_pkg::ST_ENABLE && |ack_hit)
      term_data_oe    <= 1'b0;
  end

  // enable only in the enable step, after the settle count
  assign term_enable = (state_reg == tpw_pkg::ST_ENABLE) ? sel_reg : 16'h0000;

  // ----------------------------------------------------------
  // acknowledge check and reply capture
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_ack_reg <= 1'b0;
      reply_reg     <= tpw_pkg::WORD_RESET;
      seq_false_reg <= 1'b0;
    end
    else if (state_reg == tpw_pkg::ST_CLEAR)
    begin
      valid_ack_reg <= 1'b0;
      seq_false_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == tpw_pkg::ST_ENABLE && |ack_hit)
      begin
        valid_ack_reg <= 1'b1;
        reply_reg     <= dat_s2;
      end
      if (seq_busy && |ack_false)
        seq_false_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      par_err_reg <= 1'b0;
      ovf_reg     <= 1'b0;
    end
    else if (state_reg == tpw_pkg::ST_CHECK)
    begin
      par_err_reg <= op_write_reg && !(^reply_reg);
      ovf_reg     <= op_put_reg && !reply_reg[tpw_pkg::PERMIT_BIT];
    end
    else if (state_reg == tpw_pkg::ST_ALERT)
    begin
      par_err_reg <= 1'b0;
      ovf_reg     <= 1'b0;
    end
  end

  // false ack log and error source: set beats a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      false_reg <= 16'h0000;
    else if (wr_acc && paddr == tpw_pkg::ADDR_FALSE)
      false_reg <= (false_reg & ~pwdata[15:0]) | ack_false;
    else
      false_reg <= false_reg | ack_false;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_reg <= 4'h0;
    else
    begin
      err_reg <= ((wr_acc && paddr == tpw_pkg::ADDR_ERRSRC)
                  ? (err_reg & ~pwdata[3:0]) : err_reg)
                 | {state_reg == tpw_pkg::ST_WAIT && state_next == tpw_pkg::ST_CLEAR,
                    state_reg == tpw_pkg::ST_ENABLE && state_next == tpw_pkg::ST_CLEAR,
                    state_reg == tpw_pkg::ST_CHECK && op_write_reg && !(^reply_reg),
                    |false_reg || |ack_false};
    end
  end

  // ----------------------------------------------------------
  // answer bus
  // ----------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++)
    begin : g_ans
      assign ans_put[gb]     = reply_reg[23 - gb];
      assign ans_put[8 + gb] = reply_reg[7 - gb];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      answer_reg <= 16'h0000;
    else if (state_reg == tpw_pkg::ST_CHECK)
      answer_reg <= op_put_reg ? ans_put : reply_reg[15:0];
  end

  assign scanner_answer_bus = answer_reg;
  assign seq_busy           = (state_reg != tpw_pkg::ST_IDLE);
  // pulse only in alert and after a clean check
  assign processor_asw = (state_reg == tpw_pkg::ST_ALERT)
                         || (state_reg == tpw_pkg::ST_FINISH);

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  sequence s_accept;
    state_reg == tpw_pkg::ST_IDLE && instr_wr && pfx_ok;
  endsequence

  sequence s_half_us;
    processor_asw ##124 processor_asw ##1 !processor_asw;
  endsequence

  AST_ASW_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    s_accept |=> s_half_us) else $error("asw pulse length wrong");

  AST_SEL_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
    term_data_oe |-> sel_reg == (16'h0001 << instr_reg[19:16]))
    else $error("terminal select mismatch");

  AST_OPC_EVEN: assert property (@(posedge pclk) disable iff (!presetn)
    term_data_oe |-> !(^term_opcode_bus)) else $error("opcode parity odd");

  AST_OE_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == tpw_pkg::ST_ENABLE && |ack_hit |=> !term_data_oe && valid_ack_reg)
    else $error("bus not released on ack");

  AST_PERMIT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    term_data_oe && op_put_reg |-> term_data_o[tpw_pkg::PERMIT_BIT])
    else $error("permit bit low on put");

  AST_WR_FIELDS: assert property (@(posedge pclk) disable iff (!presetn)
    term_data_oe && op_write_reg |-> ^term_data_o
      && term_data_o[20:12] == instr_reg[15:7] && term_data_o[11:0] == data_reg[11:0])
    else $error("write word malformed");

  AST_FALSE_LOG: assert property (@(posedge pclk) disable iff (!presetn)
    |ack_false |=> (false_reg & $past(ack_false)) == $past(ack_false)
      && err_reg[tpw_pkg::ERR_FALSE]) else $error("false ack not logged");

  AST_CLEAR_END: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == tpw_pkg::ST_CLEAR |=> data_reg == 24'h000000
      && term_enable == 16'h0000 && !term_data_oe) else $error("clear incomplete");

  AST_ASW_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == tpw_pkg::ST_CHECK && !chk_ok |=> !processor_asw[*2])
    else $error("asw after failed check");

endmodule : tpw_ctrl

/* core/tpw_pkg.sv */
/*
  tpw_pkg: constants, register map and state codes for the
  terminal put/write controller.
  assumes: a 250 MHz pclk and a 32-bit APB register port.
*/
// What this block does
// - list-store opcode: alert, flag, half-microsecond pulse
// - data enable decodes terminal number to one-hot
// - drive opcode bits with even parity bit
// - drive data bus only while release active
// - put data word, then enable terminal
// - data bit 23 high carries operation permit
// - valid ack only from the addressed terminal
// - log unaddressed acks, set error source bit
// - capture data bus into 24-bit reply register
// - list store answer: reply 24..17, 8..1
// - finish: drop enable, clear flops and data
// - memory write opcode: alert, write flag, answer
// - write word: data, address, data 19-20, parity
// - write gates low data half plus address
// - write bit 24 is odd parity over 23
// - valid ack: check reply, answer reply 1..16
// - write answer needs ack, no false ack, parity
// - opcode top bit zero, prefix selects class
package tpw_pkg;

  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR   = 8'h00;
  localparam logic [7:0] ADDR_DATA    = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_REPLY   = 8'h0C;
  localparam logic [7:0] ADDR_ANSWER  = 8'h10;
  localparam logic [7:0] ADDR_FALSE   = 8'h14;
  localparam logic [7:0] ADDR_ERRSRC  = 8'h18;

  // ----------------------------------------------------------
  // fields
  // ----------------------------------------------------------
  localparam int OPC_LSB    = 0;
  localparam int ADDR_LSB   = 7;
  localparam int TERM_LSB   = 16;
  localparam int PERMIT_BIT = 22;
  localparam logic [1:0] PFX_PUT   = 2'h2;
  localparam logic [1:0] PFX_WRITE = 2'h3;
  localparam int ERR_FALSE  = 0;
  localparam int ERR_PARITY = 1;
  localparam int ERR_TMO    = 2;
  localparam int ERR_REJECT = 3;
  localparam logic [23:0] WORD_RESET = 24'h000000;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_MHZ     = 250;
  localparam int ASW_NS      = 500;
  localparam int SETTLE_NS   = 8;
  localparam int ACK_TMO_NS  = 2000;
  localparam logic [9:0] ASW_CYC =
    10'((ASW_NS * CLK_MHZ) / 1000);
  localparam logic [9:0] SETTLE_CYC =
    10'((SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] ACK_TMO_CYC =
    10'((ACK_TMO_NS * CLK_MHZ) / 1000);

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ALERT  = 8'h02,
    ST_WAIT   = 8'h04,
    ST_DRIVE  = 8'h08,
    ST_ENABLE = 8'h10,
    ST_CHECK  = 8'h20,
    ST_FINISH = 8'h40,
    ST_CLEAR  = 8'h80
  } tpw_state_t;

endpackage : tpw_pkg

/* core/tpw_word_builder.sv */
/*
  tpw_word_builder: terminal select decode and outgoing words.
  assumes: instruction and data words held stable by the caller.
*/
`timescale 1ns/1ps
module tpw_word_builder (
  input  wire logic [23:0] instr,
  input  wire logic [23:0] data,
  input  wire logic        is_write,
  output logic      [15:0] sel_onehot,
  output logic      [7:0]  opcode_par,
  output logic      [23:0] word
);

  logic [3:0]  term_num;
  logic [6:0]  opc;
  logic [22:0] wr_low;

  assign term_num = instr[tpw_pkg::TERM_LSB +: 4];
  assign opc      = instr[tpw_pkg::OPC_LSB +: 7];

  // ----------------------------------------------------------
  // one-of-sixteen select
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_sel
      assign sel_onehot[gi] = (term_num == 4'(gi));
    end
  endgenerate

  // even parity bit appended above the opcode
  assign opcode_par = {^opc, opc};

  // ----------------------------------------------------------
  // data bus word
  // ----------------------------------------------------------
  assign wr_low = {data[19:18],
                   instr[tpw_pkg::ADDR_LSB +: 9],
                   data[11:0]};

  always_comb
  begin
    if (is_write)
      word = {~^wr_low, wr_low};
    else
    begin
      word = data;
      word[tpw_pkg::PERMIT_BIT] = 1'b1;
    end
  end

endmodule : tpw_word_builder

/* testbench/tpw_term_model.sv */
/*
  tpw_term_model: sixteen terminals on the enable, acknowledge and
  two-way data lines; it also resolves the data bus.
  assumes: the bench sets ovf, false_mask and ack_dly between sequences.
*/
`timescale 1ns/1ps
module tpw_term_model (
  input  wire logic        pclk,
  input  wire logic [15:0] term_enable,
  input  wire logic [23:0] term_data_o,
  input  wire logic        term_data_oe,
  input  wire logic        ovf,
  input  wire logic [15:0] false_mask,
  input  wire logic [3:0]  ack_dly,
  output logic      [15:0] ack,
  output logic      [23:0] bus
);
  logic [23:0] last;
  logic [3:0]  cnt;

  // ----------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------
  initial
  begin
    ack  = 16'h0000;
    last = 24'h000000;
    cnt  = 4'h0;
  end
  // ack held with the data until enable falls
  always @(posedge pclk)
  begin
    if (term_enable == 16'h0000)
    begin
      cnt <= 4'h0;
      ack <= 16'h0000;
    end
    else if (cnt >= ack_dly)
      ack <= term_enable | false_mask;
    else
      cnt <= cnt + 4'h1;
  end

  // ----------------------------------------------------------
  // data bus
  // ----------------------------------------------------------
  always @(posedge pclk)
    if (term_data_oe)
      last <= bus;
  // released bus shows the inverse, so a stale capture cannot pass
  assign bus = term_data_oe ? (term_data_o & ~(24'(ovf & |term_enable) << 22)) : ~last;
endmodule : tpw_term_model

/* testbench/terminal_put_write_ctrl_bench.sv */
/*
  terminal_put_write_ctrl_bench: self-checking bench for tpw_ctrl.
  assumes: tpw_pkg compiled first; tpw_term_model stands for terminals.
*/
`timescale 1ns/1ps
module terminal_put_write_ctrl_bench;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  term_opcode_bus;
  logic [15:0] term_enable;
  logic [23:0] term_data_o;
  logic        term_data_oe;
  logic [23:0] term_data_i;
  logic [15:0] terminal_ack_line;
  logic        processor_asw;
  logic [15:0] scanner_answer_bus;
  logic        seq_busy;
  logic        ovf;
  logic [15:0] false_mask;
  logic [3:0]  ack_dly;
  logic [31:0] rd;
  logic        err;
  logic [15:0] ans_seen;
  int          asw_hi;
  int          error_cnt;
  int          n_compared;

  tpw_ctrl i_tpw_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .term_opcode_bus(term_opcode_bus), .term_enable(term_enable),
    .term_data_o(term_data_o), .term_data_oe(term_data_oe), .term_data_i(term_data_i),
    .terminal_ack_line(terminal_ack_line), .processor_asw(processor_asw),
    .scanner_answer_bus(scanner_answer_bus), .seq_busy(seq_busy));
  tpw_term_model i_tpw_term_model (.pclk(pclk), .term_enable(term_enable),
    .term_data_o(term_data_o), .term_data_oe(term_data_oe), .ovf(ovf),
    .false_mask(false_mask), .ack_dly(ack_dly), .ack(terminal_ack_line), .bus(term_data_i));

  // ----------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 50)
      chk("pready wait", 32'h1, 32'h0);
    if (i == 50)
      stop_test();
  endtask : apb

  // bounded wait, sampled mid-cycle; also tallies asw high cycles
  task automatic wait_for(input int which, input logic lvl, input int lim);
    int   n;
    logic s;
    n = 0;
    do
    begin
      @(negedge pclk);
      if (processor_asw === 1'b1)
      begin
        asw_hi++;
        ans_seen = scanner_answer_bus;
      end
      s = (which == 0) ? processor_asw : (which == 1) ? seq_busy : |term_enable;
      n++;
    end
    while (s !== lvl && n < lim);
    if (s !== lvl)
    begin
      chk("wait level", 32'(lvl), 32'(s));
      stop_test();
    end
  endtask : wait_for

  // instruction word, then data word, then judge the terminal side
  task automatic run_seq(input logic [23:0] instr, input logic [23:0] data,
                         input logic [23:0] word, input logic [23:0] rep,
                         input logic [15:0] ans, input logic ok);
    logic [6:0] opc;
    opc = instr[6:0];
    asw_hi = 0;
    apb(1'b1, tpw_pkg::ADDR_INSTR, {8'h00, instr});
    wait_for(0, 1'b1, 300);
    wait_for(0, 1'b0, 300);
    chk("instr asw", 32'(tpw_pkg::ASW_CYC), asw_hi);
    apb(1'b1, tpw_pkg::ADDR_DATA, {8'h00, data});
    wait_for(2, 1'b1, 50);
    chk("enable", {16'h0000, 16'h0001 << instr[19:16]}, 32'(term_enable));
    chk("opcode bus", {24'h0, ^opc, opc}, 32'(term_opcode_bus));
    chk("drive", 32'h1, 32'(term_data_oe));
    chk("word", 32'(word), 32'(term_data_o));
    asw_hi = 0;
    wait_for(1, 1'b0, 1000);
    chk("data asw", ok ? 32'(tpw_pkg::ASW_CYC) : 32'h0, asw_hi);
    chk("release", 32'h0, {31'h0, term_data_oe});
    chk("enable off", 32'h0, 32'(term_enable));
    if (ok)
      chk("answer", 32'(ans), 32'(ans_seen));
    apb(1'b0, tpw_pkg::ADDR_REPLY, 32'h0);
    chk("reply", 32'(rep), rd);
  endtask : run_seq

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic sc_put;
    logic [23:0] d;
    logic [23:0] r;
    logic [15:0] a;
    for (int i = 0; i < 16; i++)
    begin
      d = {8'hC5 ^ 8'(i), 16'h3C0F + 16'(i * 16'h0111)} | 24'h400000;
      r = (i == 5) ? (d & 24'hBFFFFF) : d;
      for (int k = 0; k < 8; k++)
      begin
        a[k]   = r[23 - k];
        a[8+k] = r[7 - k];
      end
      ovf     <= (i == 5);
      ack_dly <= 4'(i);
      run_seq({4'h0, 4'(15 - i), 9'h0, 3'h2, 4'(i)}, d, d, r, a, 1'b1);
    end
    ovf <= 1'b0;
  endtask : sc_put

  task automatic sc_write(input logic [15:0] fm);
    logic [3:0]  codes [10] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    logic [23:0] d;
    logic [23:0] w;
    logic [8:0]  ad;
    for (int i = 0; i < ((fm != 16'h0) ? 1 : 10); i++)
    begin
      d  = 24'hF5A3C1 ^ 24'(i * 24'h0A0503);
      ad = 9'h1A5 ^ 9'(i * 9'h027);
      w  = {1'b0, d[19:18], ad, d[11:0]};
      w[23] = ~^w[22:0];
      false_mask <= fm;
      ack_dly    <= 4'(3 * i);
      run_seq({4'h0, 4'(i + 3), ad, 3'h3, codes[i]}, d, w, w, w[15:0], fm == 16'h0);
    end
    false_mask <= 16'h0000;
  endtask : sc_write

  task automatic sc_false;
    sc_write(16'h0040);
    apb(1'b0, tpw_pkg::ADDR_FALSE, 32'h0);
    chk("false ack log", 32'h0040, rd);
    apb(1'b0, tpw_pkg::ADDR_ERRSRC, 32'h0);
    chk("error source", 32'h1, rd);
    apb(1'b1, tpw_pkg::ADDR_FALSE, 32'h0040);
    apb(1'b1, tpw_pkg::ADDR_ERRSRC, 32'h1);
    apb(1'b0, tpw_pkg::ADDR_ERRSRC, 32'h0);
    chk("error source clear", 32'h0, rd);
  endtask : sc_false

  task automatic sc_refuse;
    logic [6:0] opc [3] = '{7'h06, 7'h17, 7'h60};
    int         hits;
    for (int i = 0; i < 3; i++)
    begin
      hits = 0;
      apb(1'b1, tpw_pkg::ADDR_INSTR, {12'h0, 4'h3, 9'h0, opc[i]});
      repeat (200)
      begin
        @(negedge pclk);
        hits += int'(processor_asw === 1'b1 || seq_busy === 1'b1);
      end
      chk("refused opcode", 32'h0, hits);
    end
    apb(1'b1, tpw_pkg::ADDR_INSTR, 32'h00020020);
    wait_for(0, 1'b1, 300);
    wait_for(0, 1'b0, 300);
    apb(1'b1, tpw_pkg::ADDR_DATA, 32'h00000001);
    wait_for(1, 1'b0, 50);
    apb(1'b0, tpw_pkg::ADDR_ERRSRC, 32'h0);
    chk("permit reject", 32'h8, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask : sc_refuse

  initial
  begin
    presetn    = 1'b0;
    paddr      = 8'h00;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    pwdata     = 32'h0;
    ovf        = 1'b0;
    false_mask = 16'h0000;
    ack_dly    = 4'h0;
    error_cnt  = 0;
    n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    sc_put();
    sc_write(16'h0000);
    sc_false();
    sc_refuse();
    stop_test();
  end
endmodule : terminal_put_write_ctrl_bench
